// >>> adt_top.sv
// attach detect timing: supply, bus power, id and reset filtering
// Notes on behaviour
// - main supply good after 8.5 ms high
// - main supply loss after 2.5 ms low
// - bus power filtered 4.5 ms both ways
// - id delay 100 ms per code step
// - id float change needs 20 ms
// - short test: source on 20 ms, judge
// - key comparator debounced 20 ms
// - io supply: 875 us rise, 125 us fall
// - both i2c lines low 13.5 ms resets
// - overvoltage filtered only on release
// - internal 100 kHz timing oscillator
// - i2c inputs reject short glitches
// - discharge on whenever power switch off
// - io supply falling edge resets device
// - standby polls id every 50 ms
`timescale 1ns/1ps
module adt_top
  import adt_pkg::*;
#(
  parameter int OSC_DIV_P = OSC_DIV,
  parameter int STEP_TK   = ID_DELAY_STEP_TK
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       main_supply_raw,
  input  wire logic       bus_power_raw,
  input  wire logic       io_supply_input,
  input  wire logic       accessory_id_pin_float,
  input  wire logic       id_short_cmp,
  input  wire logic       key_cmp,
  input  wire logic       overvoltage_raw,
  input  wire logic       i2c_scl_in,
  input  wire logic       i2c_sda_in,
  input  wire logic       power_switch_on,
  input  wire logic       id_delay_load,
  input  wire logic [3:0] id_delay_code_in,
  output logic            main_supply_good,
  output logic            bus_power_present,
  output logic            io_supply_good,
  output logic            id_float,
  output logic            key_pressed,
  output logic            overvoltage_guard,
  output logic            id_detect_start,
  output logic            id_short_src_en,
  output logic            id_shorted,
  output logic            id_short_done,
  output logic            standby_poll,
  output logic            attach_active,
  output logic            discharge_on,
  output logic            scl_filt,
  output logic            sda_filt,
  output logic            device_reset,
  output logic [3:0]      id_delay_code
);
  ////////////////////////////////////////////////////////////////////////
  // internal oscillator tick
  logic [TMR_W-1:0] osc_ff;
  wire  logic       tick = osc_ff == TMR_W'(OSC_DIV_P - 1);

  // free running divider standing in for the oscillator
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) osc_ff <= '0;
    else     osc_ff <= tick ? '0 : osc_ff + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // slow filters on oscillator ticks
  logic vdd_f, vbus_f, ios_f, idf_f, key_f, scl_g, sda_g;

  adt_filter u_vdd (.core_clk(core_clk), .rst(rst), .step(tick),
    .raw(main_supply_raw), .rise_len(TMR_W'(VDD_RISE_TK)),
    .fall_len(TMR_W'(VDD_FALL_TK)), .filt(vdd_f));
  adt_filter u_vbus (.core_clk(core_clk), .rst(rst), .step(tick),
    .raw(bus_power_raw), .rise_len(TMR_W'(VBUS_DGT_TK)),
    .fall_len(TMR_W'(VBUS_DGT_TK)), .filt(vbus_f));
  adt_filter #(.RST_VAL(1'b1)) u_ios (.core_clk(core_clk), .rst(rst),
    .step(tick), .raw(io_supply_input),
    .rise_len(TMR_W'(IOS_RISE_TK)),
    .fall_len(TMR_W'(IOS_FALL_TK)), .filt(ios_f));
  adt_filter #(.RST_VAL(1'b1)) u_idf (.core_clk(core_clk), .rst(rst),
    .step(tick), .raw(accessory_id_pin_float),
    .rise_len(TMR_W'(ID_FLOAT_TK)),
    .fall_len(TMR_W'(ID_FLOAT_TK)), .filt(idf_f));
  adt_filter u_key (.core_clk(core_clk), .rst(rst), .step(tick),
    .raw(key_cmp), .rise_len(TMR_W'(KEY_DBNC_TK)),
    .fall_len(TMR_W'(KEY_DBNC_TK)), .filt(key_f));

  ////////////////////////////////////////////////////////////////////////
  // fast filters on core cycles
  logic ovg_rel;
  adt_filter #(.RST_VAL(1'b1)) u_scl (.core_clk(core_clk), .rst(rst),
    .step(1'b1), .raw(i2c_scl_in), .rise_len(TMR_W'(I2C_DGT_CYC)),
    .fall_len(TMR_W'(I2C_DGT_CYC)), .filt(scl_g));
  adt_filter #(.RST_VAL(1'b1)) u_sda (.core_clk(core_clk), .rst(rst),
    .step(1'b1), .raw(i2c_sda_in), .rise_len(TMR_W'(I2C_DGT_CYC)),
    .fall_len(TMR_W'(I2C_DGT_CYC)), .filt(sda_g));
  // rise length 1 lets the filter pass; the trip itself bypasses it
  adt_filter u_ovg (.core_clk(core_clk), .rst(rst), .step(1'b1),
    .raw(overvoltage_raw), .rise_len(TMR_W'(1)),
    .fall_len(TMR_W'(OVG_FALL_CYC)), .filt(ovg_rel));
  assign overvoltage_guard = overvoltage_raw | ovg_rel;

  ////////////////////////////////////////////////////////////////////////
  // reset sources: io supply fall and i2c held low
  logic             ios_d_ff;
  logic [TMR_W-1:0] i2c_low_ff;
  logic             i2c_rst_ff;
  logic             ios_rst_ff;
  wire  logic       both_low = !scl_g && !sda_g;
  wire  logic       i2c_hit  = both_low && tick &&
                               (i2c_low_ff + 1'b1 >= TMR_W'(I2C_RST_TK));
  // the 125 us fall filter already rejects pulses the host must not rely on
  wire  logic       ios_fall = ios_d_ff && !ios_f;

  // held-low counter; any high on either line restarts it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      i2c_low_ff <= '0;
      i2c_rst_ff <= 1'b0;
      ios_d_ff   <= 1'b1;
      ios_rst_ff <= 1'b0;
    end else begin
      if (!both_low || i2c_hit) i2c_low_ff <= '0;
      else if (tick)            i2c_low_ff <= i2c_low_ff + 1'b1;
      i2c_rst_ff <= i2c_hit;
      ios_d_ff   <= ios_f;
      ios_rst_ff <= ios_fall;
    end
  end

  wire logic soft_rst = i2c_rst_ff | ios_rst_ff;
  assign device_reset = soft_rst;

  ////////////////////////////////////////////////////////////////////////
  // id delay code, reloaded to default by every reset
  logic [3:0] code_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)                code_ff <= ID_DELAY_RST;
    else if (soft_rst)      code_ff <= ID_DELAY_RST;
    else if (id_delay_load) code_ff <= id_delay_code_in;
  end
  assign id_delay_code = code_ff;

  ////////////////////////////////////////////////////////////////////////
  // detection sequencer
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_DELAY = 5'h02,
    ST_SHORT = 5'h04,
    ST_STBY  = 5'h08,
    ST_ACT   = 5'h10
  } adt_state_e;

  adt_state_e       st_ff, nxt_st;
  logic [TMR_W-1:0] tmr_ff, nxt_tmr;
  logic [4:0]       step_ff, nxt_step;
  logic             vbus_d_ff, short_ff, nxt_short;
  logic             start_ff, nxt_start, done_ff, nxt_done;
  logic             poll_ff, nxt_poll;
  wire  logic       vbus_rise = vbus_f && !vbus_d_ff;
  wire  logic [4:0] steps     = {1'b0, code_ff} + 5'h01;   // code 0 is 100 ms

  // one timer shared; a new bus arrival restarts the delay
  always_comb begin
    nxt_st    = st_ff;
    nxt_tmr   = tmr_ff;
    nxt_step  = step_ff;
    nxt_short = short_ff;
    nxt_start = 1'b0;
    nxt_done  = 1'b0;
    nxt_poll  = 1'b0;
    if (vbus_rise) begin
      nxt_st   = ST_DELAY;
      nxt_tmr  = '0;
      nxt_step = '0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (vdd_f) begin
            nxt_st  = ST_STBY;
            nxt_tmr = '0;
          end
        end
        ST_DELAY: begin
          if (tick) begin
            if (tmr_ff + 1'b1 >= TMR_W'(STEP_TK)) begin
              nxt_tmr  = '0;
              nxt_step = step_ff + 1'b1;
              if (step_ff + 1'b1 >= steps) begin
                nxt_st    = ST_SHORT;
                nxt_start = 1'b1;
              end
            end else begin
              nxt_tmr = tmr_ff + 1'b1;
            end
          end
        end
        ST_SHORT: begin
          if (tick) begin
            if (tmr_ff + 1'b1 >= TMR_W'(ID_SHORT_TK)) begin
              nxt_short = id_short_cmp;
              nxt_done  = 1'b1;
              nxt_tmr   = '0;
              nxt_st    = ST_ACT;
            end else begin
              nxt_tmr = tmr_ff + 1'b1;
            end
          end
        end
        ST_STBY: begin
          if (!vdd_f) begin
            nxt_st = ST_IDLE;
          end else if (tick) begin
            if (tmr_ff + 1'b1 >= TMR_W'(STANDBY_POLL_TK)) begin
              nxt_tmr  = '0;
              nxt_poll = 1'b1;
              if (!idf_f) begin
                nxt_st    = ST_SHORT;
                nxt_start = 1'b1;
              end
            end else begin
              nxt_tmr = tmr_ff + 1'b1;
            end
          end
        end
        ST_ACT: begin
          if (idf_f && !vbus_f) begin
            nxt_st  = vdd_f ? ST_STBY : ST_IDLE;
            nxt_tmr = '0;
          end
        end
        default: nxt_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff     <= ST_IDLE;
      tmr_ff    <= '0;
      step_ff   <= '0;
      short_ff  <= 1'b0;
      start_ff  <= 1'b0;
      done_ff   <= 1'b0;
      poll_ff   <= 1'b0;
      vbus_d_ff <= 1'b0;
    end else if (soft_rst) begin
      st_ff     <= ST_IDLE;
      tmr_ff    <= '0;
      step_ff   <= '0;
      short_ff  <= 1'b0;
      start_ff  <= 1'b0;
      done_ff   <= 1'b0;
      poll_ff   <= 1'b0;
      vbus_d_ff <= vbus_f;
    end else begin
      st_ff     <= nxt_st;
      tmr_ff    <= nxt_tmr;
      step_ff   <= nxt_step;
      short_ff  <= nxt_short;
      start_ff  <= nxt_start;
      done_ff   <= nxt_done;
      poll_ff   <= nxt_poll;
      vbus_d_ff <= vbus_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign main_supply_good  = vdd_f;
  assign bus_power_present = vbus_f;
  assign io_supply_good    = ios_f;
  assign id_float          = idf_f;
  assign key_pressed       = key_f;
  assign scl_filt          = scl_g;
  assign sda_filt          = sda_g;
  assign id_detect_start   = start_ff;
  assign id_short_src_en   = st_ff == ST_SHORT;
  assign id_shorted        = short_ff;
  assign id_short_done     = done_ff;
  assign standby_poll      = poll_ff;
  assign attach_active     = st_ff == ST_ACT;
  assign discharge_on      = !power_switch_on;
endmodule

// >>> adt_pkg.sv
// shared timing constants for the attach detect timing block
package adt_pkg;
  // core clock and internal oscillator
  localparam int CORE_CLK_HZ      = 100_000_000;
  localparam int OSC_HZ           = 100_000;
  localparam int OSC_DIV          = CORE_CLK_HZ / OSC_HZ;   // 1000 cycles
  // millisecond timers counted in oscillator ticks (10 us each)
  localparam int TICK_US          = 10;
  localparam int VDD_RISE_US      = 8500;
  localparam int VDD_FALL_US      = 2500;
  localparam int VBUS_DGT_US      = 4500;
  localparam int ID_FLOAT_US      = 20000;
  localparam int ID_SHORT_US      = 20000;
  localparam int KEY_DBNC_US      = 20000;
  localparam int IOS_RISE_US      = 875;
  localparam int IOS_FALL_US      = 125;
  localparam int I2C_RST_US       = 13500;
  localparam int OVG_FALL_US      = 25;
  localparam int STANDBY_POLL_US  = 50000;
  localparam int ID_DELAY_STEP_US = 100000;
  localparam int VDD_RISE_TK      = VDD_RISE_US / TICK_US;
  localparam int VDD_FALL_TK      = VDD_FALL_US / TICK_US;
  localparam int VBUS_DGT_TK      = VBUS_DGT_US / TICK_US;
  localparam int ID_FLOAT_TK      = ID_FLOAT_US / TICK_US;
  localparam int ID_SHORT_TK      = ID_SHORT_US / TICK_US;
  localparam int KEY_DBNC_TK      = KEY_DBNC_US / TICK_US;
  localparam int IOS_RISE_TK      = (IOS_RISE_US + TICK_US - 1) / TICK_US;
  localparam int IOS_FALL_TK      = (IOS_FALL_US + TICK_US - 1) / TICK_US;
  localparam int I2C_RST_TK       = I2C_RST_US / TICK_US;
  localparam int STANDBY_POLL_TK  = STANDBY_POLL_US / TICK_US;
  localparam int ID_DELAY_STEP_TK = ID_DELAY_STEP_US / TICK_US;
  // overvoltage release is short, counted in core cycles
  localparam int OVG_FALL_CYC     = OVG_FALL_US * (CORE_CLK_HZ / 1_000_000);
  // i2c input glitch filter, 55 to 300 ns; 100 ns sits inside that band
  localparam int I2C_DGT_NS       = 100;
  localparam int I2C_DGT_CYC      = I2C_DGT_NS / 10;
  // id delay code default after any reset
  localparam logic [3:0] ID_DELAY_RST = 4'h4;
  localparam int TMR_W            = 20;
endpackage

// >>> adt_filter.sv
// one two-sided deglitch filter with separate rise and fall times
`timescale 1ns/1ps
module adt_filter
  import adt_pkg::*;
#(
  parameter int W        = TMR_W,
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         step,
  input  wire logic         raw,
  input  wire logic [W-1:0] rise_len,
  input  wire logic [W-1:0] fall_len,
  output logic              filt
);
  logic         filt_ff;
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         nxt_filt;
  wire  logic         differ = raw != filt_ff;
  wire  logic [W-1:0] lim    = raw ? rise_len : fall_len;

  // restart the count whenever the input returns to the filtered level
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_filt = filt_ff;
    if (!differ) begin
      nxt_cnt = '0;
    end else if (step) begin
      if (cnt_ff + 1'b1 >= lim) begin
        nxt_filt = raw;
        nxt_cnt  = '0;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      filt_ff <= RST_VAL;
    end else begin
      cnt_ff  <= nxt_cnt;
      filt_ff <= nxt_filt;
    end
  end

  assign filt = filt_ff;
endmodule

// >>> adt_accessory.sv
// accessory model seen at the connector pins
`timescale 1ns/1ps
module adt_accessory (
  input  wire logic core_clk,
  input  wire logic plug_power,
  input  wire logic plug_id,
  input  wire logic shorted,
  input  wire logic src_en,
  output logic      bus_power_raw,
  output logic      id_pin_float,
  output logic      short_cmp
);
  logic junk_ff = 1'b0;
  // the short comparator means nothing unsourced, so it shows noise then
  always @(posedge core_clk) junk_ff <= !junk_ff;
  assign short_cmp     = src_en ? shorted : junk_ff;
  // an id resistor pulls the pin out of its floating state
  assign id_pin_float  = !plug_id;
  assign bus_power_raw = plug_power;
endmodule

// >>> adt_assertions.sv
// concurrent checks on the attach detect timing top ports
`timescale 1ns/1ps
module adt_checker
  import adt_pkg::*;
#(
  parameter int OSC_DIV_P = OSC_DIV
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       power_switch_on,
  input wire logic       overvoltage_raw,
  input wire logic       key_cmp,
  input wire logic       bus_power_raw,
  input wire logic       accessory_id_pin_float,
  input wire logic       i2c_scl_in,
  input wire logic       discharge_on,
  input wire logic       overvoltage_guard,
  input wire logic       key_pressed,
  input wire logic       bus_power_present,
  input wire logic       id_float,
  input wire logic       io_supply_good,
  input wire logic       device_reset,
  input wire logic       id_short_src_en,
  input wire logic       scl_filt,
  input wire logic       sda_filt,
  input wire logic [3:0] id_delay_code
);
  localparam int SRC_LO = (ID_SHORT_TK - 1) * OSC_DIV_P;
  localparam int SRC_HI = (ID_SHORT_TK + 1) * OSC_DIV_P;
  int src_cnt_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // length of the current source burst in core cycles
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) src_cnt_ff <= 0;
    else src_cnt_ff <= id_short_src_en ? src_cnt_ff + 1 : 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  discharge_mirror_a: assert property (
    discharge_on == !power_switch_on) else $error("discharge level");
  ovg_trip_a: assert property (
    overvoltage_raw |-> overvoltage_guard) else $error("ovg trip late");
  ovg_release_a: assert property (
    $fell(overvoltage_raw) |-> overvoltage_guard [*8])
    else $error("ovg release unfiltered");
  key_debounce_a: assert property (
    $changed(key_pressed) |-> key_pressed == $past(key_cmp, 8))
    else $error("key change unsteady");
  vbus_filter_a: assert property (
    $changed(bus_power_present) |->
    bus_power_present == $past(bus_power_raw, 8)) else $error("vbus");
  id_float_a: assert property (
    $changed(id_float) |-> id_float == $past(accessory_id_pin_float, 8))
    else $error("id float change unsteady");
  scl_glitch_a: assert property (
    $changed(scl_filt) |-> scl_filt == $past(i2c_scl_in, 8))
    else $error("scl glitch passed");
  io_fall_reset_a: assert property (
    $fell(io_supply_good) |=> device_reset) else $error("no io reset");
  reset_reload_a: assert property (
    device_reset |=> !device_reset && id_delay_code == ID_DELAY_RST)
    else $error("reset strobe or code reload");
  i2c_reset_a: assert property (
    device_reset && io_supply_good |-> !$past(scl_filt, 8) &&
    !$past(sda_filt, 8)) else $error("i2c reset without bus low");
  short_time_a: assert property (
    $fell(id_short_src_en) |-> src_cnt_ff inside {[SRC_LO:SRC_HI]})
    else $error("short test source time");
endmodule
bind adt_top adt_checker #(.OSC_DIV_P(OSC_DIV_P)) u_chk (.*);

// >>> attach_detect_timing_bench.sv
// self-checking bench for the attach detect timing block
`timescale 1ns/1ps
module attach_detect_timing_bench;
  import adt_pkg::*;
  localparam int DIV   = 2;
  localparam int STK   = 4;
  localparam int LIMIT = 100000;
  logic       core_clk, rst, main_supply_raw, io_supply_input, key_cmp;
  logic       overvoltage_raw, i2c_scl_in, i2c_sda_in, power_switch_on;
  logic       id_delay_load, plug_power, plug_id, shorted;
  logic [3:0] id_delay_code_in, id_delay_code;
  logic       bus_power_raw, accessory_id_pin_float, id_short_cmp;
  logic       main_supply_good, bus_power_present, io_supply_good, id_float;
  logic       key_pressed, overvoltage_guard, id_detect_start, id_shorted;
  logic       id_short_src_en, id_short_done, standby_poll, attach_active;
  logic       discharge_on, scl_filt, sda_filt, device_reset;
  int         err_count = 0, n_checks = 0, cyc = 0, n_rst = 0, t0, n0;
  adt_top #(.OSC_DIV_P(DIV), .STEP_TK(STK)) DUT (.*);
  adt_accessory u_acc (
    .core_clk     (core_clk),
    .plug_power   (plug_power),
    .plug_id      (plug_id),
    .shorted      (shorted),
    .src_en       (id_short_src_en),
    .bus_power_raw(bus_power_raw),
    .id_pin_float (accessory_id_pin_float),
    .short_cmp    (id_short_cmp)
  );
  ////////////////////////////////////////////////////////////////////////////
  // clock; hang guard keeps a stuck wait from running forever
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (device_reset === 1'b1) n_rst <= n_rst + 1;
    if (cyc == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (e !== g) begin
      err_count++;
      $display("mismatch %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int lo, hi, d);
    n_checks++;
    if (d < lo || d > hi) begin
      err_count++;
      $display("mismatch %s exp %0d..%0d got %0d", nm, lo, hi, d);
    end
  endtask
  // tick counts carry one tick of oscillator phase either way
  task automatic tk(input string nm, input int n, d);
    rng(nm, (n - 1) * DIV, (n + 1) * DIV + 2, d);
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic ld(input logic [3:0] c);
    @(posedge core_clk) id_delay_code_in <= c;
    id_delay_load <= 1'b1;
    @(posedge core_clk) id_delay_load <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_ovg();
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk) power_switch_on <= i[0];
      #1 chk("discharge", !i[0], discharge_on);
    end
    @(posedge core_clk) overvoltage_raw <= 1'b1;
    #1 chk("ovg_trip", 1'b1, overvoltage_guard);
    cy(4);
    overvoltage_raw <= 1'b0;
    #1 t0 = cyc;
    @(negedge overvoltage_guard) #1
      rng("ovg_rel", OVG_FALL_CYC - 2, OVG_FALL_CYC + 4, cyc - t0);
  endtask
  task automatic t_key();
    @(posedge core_clk) key_cmp <= 1'b1;
    cy(1900 * DIV);
    key_cmp <= 1'b0;
    cy(100 * DIV);
    #1 chk("key_short", 1'b0, key_pressed);
    @(posedge core_clk) key_cmp <= 1'b1;
    #1 t0 = cyc;
    @(posedge key_pressed) #1 tk("key", KEY_DBNC_TK, cyc - t0);
    @(posedge core_clk) key_cmp <= 1'b0;
    @(negedge key_pressed);
  endtask
  task automatic t_attach(input logic [3:0] c, input logic sh);
    ld(c);
    #1 chk("code_load", c, id_delay_code);
    @(posedge core_clk) plug_power <= 1'b1;
    shorted <= sh;
    #1 t0 = cyc;
    @(posedge bus_power_present) #1
      tk("vbus_on", VBUS_DGT_TK, cyc - t0);
    t0 = cyc;
    @(posedge id_detect_start) #1 tk("delay", (c + 1) * STK, cyc - t0);
    t0 = cyc;
    @(negedge id_short_src_en) #1 tk("src", ID_SHORT_TK, cyc - t0);
    chk("short_done", 1'b1, id_short_done);
    cy(4);
    #1 chk("shorted", sh, id_shorted);
    chk("active", 1'b1, attach_active);
    @(posedge core_clk) plug_power <= 1'b0;
    #1 t0 = cyc;
    @(negedge bus_power_present) #1
      tk("vbus_off", VBUS_DGT_TK, cyc - t0);
  endtask
  task automatic t_main();
    @(posedge core_clk) main_supply_raw <= 1'b1;
    cy(800 * DIV);
    main_supply_raw <= 1'b0;
    cy(900 * DIV);
    #1 chk("main_glitch", 1'b0, main_supply_good);
    @(posedge core_clk) main_supply_raw <= 1'b1;
    #1 t0 = cyc;
    @(posedge main_supply_good) #1
      tk("main_on", VDD_RISE_TK, cyc - t0);
    @(posedge core_clk) main_supply_raw <= 1'b0;
    cy(200 * DIV);
    main_supply_raw <= 1'b1;
    #1 chk("main_hold", 1'b1, main_supply_good);
    @(posedge standby_poll) #1 t0 = cyc;
    @(posedge standby_poll) #1 tk("poll", STANDBY_POLL_TK, cyc - t0);
    @(posedge core_clk) plug_id <= 1'b1;
    #1 t0 = cyc;
    @(negedge id_float) #1 tk("id_float", ID_FLOAT_TK, cyc - t0);
    t0 = cyc;
    @(posedge id_detect_start) #1
      rng("poll_go", 0, STANDBY_POLL_TK * DIV + 4, cyc - t0);
    @(negedge id_short_src_en) cy(4);
    #1 chk("stby_active", 1'b1, attach_active);
    @(posedge core_clk) plug_id <= 1'b0;
    main_supply_raw <= 1'b0;
    #1 t0 = cyc;
    @(negedge main_supply_good) #1
      tk("main_off", VDD_FALL_TK, cyc - t0);
  endtask
  task automatic t_io();
    ld(4'h9);
    n0 = n_rst;
    @(posedge core_clk) io_supply_input <= 1'b0;
    cy(8 * DIV);
    io_supply_input <= 1'b1;
    cy(100 * DIV);
    #1 chk("io_glitch", n0, n_rst);
    @(posedge core_clk) io_supply_input <= 1'b0;
    #1 t0 = cyc;
    @(posedge device_reset) #1 tk("io_fall", IOS_FALL_TK, cyc - t0);
    @(posedge core_clk) #1
      chk("code_io", ID_DELAY_RST, id_delay_code);
    cy(3 * DIV);
    io_supply_input <= 1'b1;
    #1 t0 = cyc;
    @(posedge io_supply_good) #1 tk("io_rise", IOS_RISE_TK, cyc - t0);
  endtask
  task automatic t_i2c();
    @(posedge core_clk) i2c_scl_in <= 1'b0;
    cy(5);
    i2c_scl_in <= 1'b1;
    cy(20);
    #1 chk("scl_glitch", 1'b1, scl_filt);
    ld(4'h2);
    n0 = n_rst;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk) {i2c_scl_in, i2c_sda_in} <= 2'h0;
      #1 t0 = cyc;
      if (i == 0) begin
        cy(880 * DIV);
        {i2c_scl_in, i2c_sda_in} <= 2'h3;
        cy(20);
        #1 chk("i2c_short", n0, n_rst);
      end
    end
    @(posedge device_reset) #1 rng("i2c_rst", (I2C_RST_TK - 1) * DIV,
      (I2C_RST_TK + 1) * DIV + I2C_DGT_CYC + 2, cyc - t0);
    @(posedge core_clk) #1
      chk("code_i2c", ID_DELAY_RST, id_delay_code);
    @(posedge core_clk) {i2c_scl_in, i2c_sda_in} <= 2'h3;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {main_supply_raw, key_cmp, overvoltage_raw, power_switch_on} = 4'h0;
    {id_delay_load, plug_power, plug_id, shorted} = 4'h0;
    {io_supply_input, i2c_scl_in, i2c_sda_in, rst} = 4'hf;
    id_delay_code_in = 4'h0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    #1 chk("code_rst", ID_DELAY_RST, id_delay_code);
    t_ovg();
    t_key();
    t_attach(4'h4, 1'b1);
    t_attach(4'h0, 1'b0);
    t_attach(4'hf, 1'b0);
    t_main();
    t_io();
    t_i2c();
    wrap_up();
  end
endmodule
